// file: rtl/dwcrc_pkg.sv
// shared constants, types and field layout for the write-data checksum checker
package dwcrc_pkg;

  // clock and alert timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int ALERT_LAT_MIN_NS = 3;
  localparam int ALERT_LAT_MAX_NS = 13;
  localparam int ALERT_LAT_MIN_CYC =
    ((ALERT_LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((ALERT_LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int ALERT_LAT_MAX_CYC =
    (ALERT_LAT_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (ALERT_LAT_MAX_NS / CLK_PERIOD_NS);
  localparam int ALERT_PW_MIN_TCK = 6;
  localparam int ALERT_PW_MAX_TCK = 10;

  // frame geometry
  localparam int FRAME_XFERS     = 10;
  localparam int BURST_XFERS     = 8;
  localparam int CRC_XFER        = 8;
  localparam int CRC_HI_XFER     = 9;
  localparam int CODE_W          = 72;
  localparam int DQ_LANES        = 16;
  localparam int NUM_LANES       = 18;
  localparam int LOWER_MASK_LANE = 16;
  localparam int UPPER_MASK_LANE = 17;
  localparam logic [7:0] CRC_POLY = 8'h07;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_MODE_FIVE  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MPR_THREE  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CRC_CALC   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CRC_RECV   = 4'h3;

  // mode register five fields
  localparam int MR5_CRC_EN  = 0;
  localparam int MR5_DM_EN   = 1;
  localparam int MR5_DBI_EN  = 2;
  localparam int MR5_ERR_CLR = 3;
  localparam int MR5_WID_LO  = 4;
  localparam int MR5_WID_HI  = 5;
  localparam logic [DATA_W-1:0] MR5_RESET = 16'h0010;
  localparam int MULTIPURPOSE_REGISTER_THREE_ERR    = 0;

  // device width select
  typedef enum logic [1:0] {
    DWCRC_X4  = 2'h0,
    DWCRC_X8  = 2'h1,
    DWCRC_X16 = 2'h2
  } dwcrc_width_t;

  // alert pulse sequencer, one-hot
  typedef enum logic [2:0] {
    DWCRC_IDLE  = 3'h1,
    DWCRC_PULSE = 3'h2,
    DWCRC_GAP   = 3'h4
  } dwcrc_alert_st_t;

  // link pins sampled together
  typedef struct packed {
    logic                 strobe;
    logic                 frame;
    logic [NUM_LANES-1:0] lanes;
  } dwcrc_pins_t;

endpackage

// file: rtl/dwcrc_tree.sv
// parallel 8-bit checksum tree over one 72-bit code word
`timescale 1ns/100ps
module dwcrc_tree
  import dwcrc_pkg::*;
(
  // code word in
  input  wire logic [CODE_W-1:0] word_in,
  // checksum out
  output logic      [7:0]        crc_out
);

  // unrolled serial division, bit 71 first from a zero state; the loop folds into a
  // flat xor tree per output bit, so bits 0..7 all come from one polynomial
  function automatic logic [7:0] crc8_of(input logic [CODE_W-1:0] d);
    logic [7:0] c;
    logic       fb;
    c  = 8'h00;
    fb = 1'b0;
    for (int i = CODE_W - 1; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // bit 6 and bit 7 equations, and bits 0 to 5, all fall out of the same tree
  assign crc_out = crc8_of(word_in);

endmodule

// file: rtl/dwcrc_top.sv
// device-side write-data checksum checker with alert pulse and error flags
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module dwcrc_top
  import dwcrc_pkg::*;
#(
  parameter int unsigned ALERT_PW_CYC = 8
)
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // register port
  input  wire logic [ADDR_W-1:0]   reg_addr_in,
  input  wire logic [DATA_W-1:0]   reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [DATA_W-1:0]   reg_rdata_out,
  // write link pins
  input  wire logic                strobe_in,
  input  wire logic                frame_in,
  input  wire logic [DQ_LANES-1:0] dq_in,
  input  wire logic                lower_mask_lane_in,
  input  wire logic                upper_mask_lane_in,
  // shared alert line, open drain
  output logic                     alert_n_out,
  output logic                     alert_oe_n_out,
  // write data toward the array
  output logic                     wr_valid_out,
  output logic [DQ_LANES*8-1:0]    wr_data_out
);

  localparam logic [3:0] PW_LAST  = 4'(ALERT_PW_CYC - 1);
  localparam logic [3:0] XFER_END = 4'(FRAME_XFERS);
  localparam logic [3:0] DATA_END = 4'(BURST_XFERS - 1);

  // pack one byte-wide half into a code word; top byte is mask/inversion or ones
  function automatic logic [CODE_W-1:0] pack_word(
    input logic [7:0][FRAME_XFERS-1:0] l,
    input logic [FRAME_XFERS-1:0]      m,
    input logic                        use_m
  );
    logic [CODE_W-1:0] w;
    w = '1;
    for (int n = 0; n < 8; n++)
    begin
      w[8*n +: 8] = l[n][7:0];
    end
    w[71:64] = use_m ? m[7:0] : 8'hFF;
    return w;
  endfunction

  // received checksum of one byte-wide half, sent in transfer 8
  function automatic logic [7:0] recv_byte(input logic [7:0][FRAME_XFERS-1:0] l);
    logic [7:0] c;
    c = 8'h00;
    for (int n = 0; n < 8; n++)
    begin
      c[n] = l[n][CRC_XFER];
    end
    return c;
  endfunction

  // pin synchronisers and edge history
  dwcrc_pins_t pins_raw;
  dwcrc_pins_t pins_s1;
  dwcrc_pins_t pins_s2;
  dwcrc_pins_t pins_s3;

  // frame capture
  logic [NUM_LANES-1:0][FRAME_XFERS-1:0] lane_q;
  logic [3:0]                            xfer_cnt;
  logic                                  check_go;
  logic                                  len_bad;
  logic                                  wr_go;

  // mode register five and status
  logic               crc_en;
  logic               dm_en;
  logic               dbi_en;
  logic               err_clr;
  logic [1:0]         width_sel;
  logic               multipurpose_register_three_err;
  logic [15:0]        crc_calc_q;
  logic [15:0]        crc_recv_q;

  // alert sequencer
  dwcrc_alert_st_t    alert_st;
  dwcrc_alert_st_t    next_alert_st;
  logic [3:0]         pw_cnt;
  logic               err_pending;

  // combinational nets
  logic               xfer_take;
  logic               frame_rise;
  logic               frame_fall;
  logic [3:0]         wr_idx;
  logic [3:0]         next_xfer_cnt;
  logic               use_mask;
  logic               is_x4;
  logic               is_x16;
  logic [CODE_W-1:0]  word_x8_lo;
  logic [CODE_W-1:0]  word_x4;
  logic [CODE_W-1:0]  word_lo;
  logic [CODE_W-1:0]  word_hi;
  logic [7:0]         calc_lo;
  logic [7:0]         calc_hi;
  logic [7:0]         recv_lo;
  logic [7:0]         recv_hi;
  logic               mismatch;
  logic               err_evt;
  logic               mr5_wr;
  logic [DATA_W-1:0]  mr5_view;
  logic [DATA_W-1:0]  rd_mux;

  // pins gathered into one word so they cross with the same latency
  assign pins_raw.strobe = strobe_in;
  assign pins_raw.frame  = frame_in;
  assign pins_raw.lanes  = {upper_mask_lane_in, lower_mask_lane_in, dq_in};

  // two-stage synchroniser; s3 only serves edge detection on the settled stage
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      pins_s3 <= '0;
    end
    else
    begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      pins_s3 <= pins_s2;
    end
  end

  // each strobe edge inside a frame is one transfer (double data rate)
  assign xfer_take  = (pins_s2.strobe ^ pins_s3.strobe) & pins_s2.frame;
  assign frame_rise = pins_s2.frame & ~pins_s3.frame;
  assign frame_fall = ~pins_s2.frame & pins_s3.frame;
  assign wr_idx     = frame_rise ? 4'h0 : xfer_cnt;

  // count saturates past the frame so an overlong frame is still caught
  assign next_xfer_cnt = frame_rise ? {3'h0, xfer_take} :
                         (xfer_take && xfer_cnt != 4'hF) ? xfer_cnt + 4'h1 : xfer_cnt;

  // transfer counter and frame-end triggers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      xfer_cnt <= 4'h0;
      check_go <= 1'b0;
      len_bad  <= 1'b0;
      wr_go    <= 1'b0;
    end
    else
    begin
      xfer_cnt <= next_xfer_cnt;
      check_go <= frame_fall & crc_en;
      len_bad  <= frame_fall & crc_en & (xfer_cnt != XFER_END);
      wr_go    <= xfer_take & (wr_idx == DATA_END);
    end
  end

  // lane storage; unsent transfers read as ones
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      lane_q <= '1;
    end
    else
    begin
      for (int l = 0; l < NUM_LANES; l++)
      begin
        if (frame_rise)
        begin
          lane_q[l] <= '1;
        end
        if (xfer_take && wr_idx < XFER_END)
        begin
          lane_q[l][wr_idx] <= pins_s2.lanes[l];
        end
      end
    end
  end

  // width decode; the reserved width code behaves as byte-wide
  assign is_x4    = (width_sel == DWCRC_X4);
  assign is_x16   = (width_sel == DWCRC_X16);
  // mask and inversion are never both on; either one puts the lane in the tree
  assign use_mask = dm_en | dbi_en;

  // code words for each width
  assign word_x8_lo = pack_word(lane_q[7:0], lane_q[LOWER_MASK_LANE], use_mask);
  assign word_x4    = {40'hFF_FFFF_FFFF, word_x8_lo[31:0]};
  assign word_lo    = is_x4 ? word_x4 : word_x8_lo;
  assign word_hi    = pack_word(lane_q[15:8], lane_q[UPPER_MASK_LANE], use_mask);

  // nibble frames carry the high checksum nibble in transfer 9
  assign recv_lo = is_x4 ? {lane_q[3][CRC_HI_XFER], lane_q[2][CRC_HI_XFER],
                            lane_q[1][CRC_HI_XFER], lane_q[0][CRC_HI_XFER],
                            lane_q[3][CRC_XFER], lane_q[2][CRC_XFER],
                            lane_q[1][CRC_XFER], lane_q[0][CRC_XFER]}
                         : recv_byte(lane_q[7:0]);
  assign recv_hi = recv_byte(lane_q[15:8]);

  // lower tree, always in use
  dwcrc_tree u_tree_lo (
    .word_in (word_lo),
    .crc_out (calc_lo)
  );

  // upper tree, only consulted for the 16-bit width
  dwcrc_tree u_tree_hi (
    .word_in (word_hi),
    .crc_out (calc_hi)
  );

  // transfer 9 of byte-wide lanes is not checked; a stray zero there is tolerated
  assign mismatch = (calc_lo != recv_lo) | (is_x16 & (calc_hi != recv_hi));
  assign err_evt  = (check_go & mismatch) | len_bad;

  // data leaves for the array after transfer 7, before the checksum arrives
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_valid_out <= 1'b0;
      wr_data_out  <= '0;
    end
    else
    begin
      wr_valid_out <= wr_go;
      for (int n = 0; n < DQ_LANES; n++)
      begin
        wr_data_out[8*n +: 8] <= lane_q[n][7:0];
      end
    end
  end

  // checksum snapshots for software
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      crc_calc_q <= 16'h0000;
      crc_recv_q <= 16'h0000;
    end
    else if (check_go)
    begin
      crc_calc_q <= {calc_hi, calc_lo};
      crc_recv_q <= {recv_hi, recv_lo};
    end
  end

  // register write decode
  assign mr5_wr = reg_wr_in & (reg_addr_in == REG_MODE_FIVE);

  // mode register five; a new error beats a clear written in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      crc_en    <= MR5_RESET[MR5_CRC_EN];
      dm_en     <= MR5_RESET[MR5_DM_EN];
      dbi_en    <= MR5_RESET[MR5_DBI_EN];
      err_clr   <= MR5_RESET[MR5_ERR_CLR];
      width_sel <= MR5_RESET[MR5_WID_HI:MR5_WID_LO];
      multipurpose_register_three_err  <= 1'b0;
    end
    else
    begin
      if (mr5_wr)
      begin
        crc_en    <= reg_wdata_in[MR5_CRC_EN];
        dm_en     <= reg_wdata_in[MR5_DM_EN];
        dbi_en    <= reg_wdata_in[MR5_DBI_EN];
        width_sel <= reg_wdata_in[MR5_WID_HI:MR5_WID_LO];
      end
      if (err_evt)
      begin
        err_clr  <= 1'b1;
        multipurpose_register_three_err <= 1'b1;
      end
      else if (mr5_wr && !reg_wdata_in[MR5_ERR_CLR])
      begin
        err_clr  <= 1'b0;
        multipurpose_register_three_err <= 1'b0;
      end
    end
  end

  // mode register five read view
  assign mr5_view[MR5_CRC_EN]            = crc_en;
  assign mr5_view[MR5_DM_EN]             = dm_en;
  assign mr5_view[MR5_DBI_EN]            = dbi_en;
  assign mr5_view[MR5_ERR_CLR]           = err_clr;
  assign mr5_view[MR5_WID_HI:MR5_WID_LO] = width_sel;
  assign mr5_view[DATA_W-1:MR5_WID_HI+1] = '0;

  // the error status bit lets software tell checksum from parity alerts
  assign rd_mux = (reg_addr_in == REG_MODE_FIVE) ? mr5_view :
                  (reg_addr_in == REG_MPR_THREE) ? {15'h0000, multipurpose_register_three_err} :
                  (reg_addr_in == REG_CRC_CALC)  ? crc_calc_q :
                  (reg_addr_in == REG_CRC_RECV)  ? crc_recv_q : 16'h0000;

  // read data stands for one cycle only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= 16'h0000;
    end
    else
    begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end

  // alert sequencer: a pulse, never a level, then two released cycles (gap, then idle) so that
  // errors back to back still show as separate pulses to the host
  always_comb
  begin
    next_alert_st = alert_st;
    case (alert_st)
      DWCRC_IDLE:
      begin
        if (err_pending)
        begin
          next_alert_st = DWCRC_PULSE;
        end
      end
      DWCRC_PULSE:
      begin
        if (pw_cnt == PW_LAST)
        begin
          next_alert_st = DWCRC_GAP;
        end
      end
      DWCRC_GAP:
      begin
        next_alert_st = DWCRC_IDLE;
      end
      default:
      begin
        next_alert_st = DWCRC_IDLE;
      end
    endcase
  end

  // pending error is taken when the pulse starts; a new one wins that cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      err_pending <= 1'b0;
    end
    else if (err_evt)
    begin
      err_pending <= 1'b1;
    end
    else if (alert_st == DWCRC_IDLE)
    begin
      err_pending <= 1'b0;
    end
  end

  // state, width counter and pin drivers, all registered
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      alert_st       <= DWCRC_IDLE;
      pw_cnt         <= 4'h0;
      alert_n_out    <= 1'b1;
      alert_oe_n_out <= 1'b1;
    end
    else
    begin
      alert_st       <= next_alert_st;
      pw_cnt         <= (alert_st == DWCRC_PULSE) ? pw_cnt + 4'h1 : 4'h0;
      alert_n_out    <= (next_alert_st != DWCRC_PULSE);
      alert_oe_n_out <= (next_alert_st != DWCRC_PULSE);
    end
  end

endmodule

// file: sim/dwcrc_top_props.sv
// concurrent checks on the ports of the write checksum checker
`timescale 1ns/100ps
module dwcrc_top_props
  import dwcrc_pkg::*;
#(
  parameter int unsigned ALERT_PW_CYC = 8
)
(
  // clock and reset
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  // register port
  input wire logic [ADDR_W-1:0]     reg_addr_in,
  input wire logic [DATA_W-1:0]     reg_wdata_in,
  input wire logic                  reg_wr_in,
  input wire logic                  reg_rd_in,
  input wire logic [DATA_W-1:0]     reg_rdata_out,
  // link pins
  input wire logic                  strobe_in,
  input wire logic                  frame_in,
  input wire logic [DQ_LANES-1:0]   dq_in,
  input wire logic                  lower_mask_lane_in,
  input wire logic                  upper_mask_lane_in,
  // alert and array side
  input wire logic                  alert_n_out,
  input wire logic                  alert_oe_n_out,
  input wire logic                  wr_valid_out,
  input wire logic [DQ_LANES*8-1:0] wr_data_out
);
  logic [4:0] low_cnt;

  // length of the running low stretch; a counter because widths reach past eight
  always_ff @(posedge clk_in)
  begin
    if (rst_in || alert_n_out)
      low_cnt <= 5'h00;
    else if (low_cnt != 5'h1F)
      low_cnt <= low_cnt + 5'h01;
  end

  default clocking cb @(posedge clk_in); endclocking

  // pulse steps
  sequence s_alert_start;
    $fell(alert_n_out);
  endsequence
  sequence s_six_low;
    !alert_n_out [*6];
  endsequence

  a_pulse_min_six: assert property (disable iff (rst_in) s_alert_start |-> s_six_low)
    else $error("alert pulse shorter than six cycles");
  a_pulse_exact_width: assert property (disable iff (rst_in) $rose(alert_n_out) |-> low_cnt == 5'(ALERT_PW_CYC))
    else $error("alert pulse width differs from setting");
  a_pulse_max_ten: assert property (disable iff (rst_in) low_cnt <= 5'h0A)
    else $error("alert held low beyond ten cycles");
  a_oe_tracks_level: assert property (disable iff (rst_in) alert_oe_n_out == alert_n_out)
    else $error("alert enable and level disagree");
  a_rdata_idle_zero: assert property (disable iff (rst_in) !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data shown without a read");
  a_valid_one_cycle: assert property (disable iff (rst_in) wr_valid_out |=> !wr_valid_out)
    else $error("array write pulse longer than one cycle");
  a_valid_in_frame: assert property (disable iff (rst_in) wr_valid_out |-> $past(frame_in, 4))
    else $error("array write outside a frame");
  a_reset_quiet: assert property (rst_in |=> alert_n_out && alert_oe_n_out && !wr_valid_out && reg_rdata_out == 16'h0000)
    else $error("outputs not idle after reset");
endmodule

bind dwcrc_top dwcrc_top_props #(.ALERT_PW_CYC(ALERT_PW_CYC)) u_props (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .strobe_in, .frame_in, .dq_in, .lower_mask_lane_in, .upper_mask_lane_in,
  .alert_n_out, .alert_oe_n_out, .wr_valid_out, .wr_data_out);

// file: sim/dwcrc_ctrl_model.sv
// behavioural memory controller that frames write bursts with their checksum
`timescale 1ns/100ps
module dwcrc_ctrl_model
  import dwcrc_pkg::*;
(
  // request from the bench
  input  wire logic                  clk_in,
  input  wire logic                  start_in,
  input  wire logic [1:0]            width_in,
  input  wire logic                  use_m_in,
  input  wire logic                  bad_in,
  input  wire logic [3:0]            nx_in,
  input  wire logic [DQ_LANES*8-1:0] data_in,
  input  wire logic [15:0]           mask_in,
  // state and the checksum that belongs to the data
  output logic                       busy_out,
  output logic [15:0]                crc_out,
  // link pins
  output dwcrc_pins_t                pins_out
);
  logic [CODE_W-1:0] lo_w;
  logic [CODE_W-1:0] hi_w;
  logic [7:0]        lo_c;
  logic [7:0]        hi_c;

  // serial form, msb first from zero, so it shares nothing with a parallel tree
  function automatic logic [7:0] crc8(input logic [CODE_W-1:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = CODE_W - 1; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction

  // lane level for one transfer; mask lanes always carry data to test forcing
  function automatic logic lane_bit(input int n, input int t);
    if (t < BURST_XFERS)
      return (n < DQ_LANES) ? data_in[8*n+t] : mask_in[8*(n-DQ_LANES)+t];
    if (width_in == 2'h0)
      return (n < 4) ? ((t == CRC_XFER) ? lo_c[n] : lo_c[n+4]) : 1'b1;
    if (t == CRC_XFER && n < 8)
      return lo_c[n];
    if (t == CRC_XFER && n < DQ_LANES && width_in == 2'h2)
      return hi_c[n-8];
    return 1'b1;
  endfunction

  initial
  begin
    busy_out = 1'b0;
    crc_out = 16'h0000;
    pins_out = {2'h0, 18'h3FFFF};
  end

  // one frame: data held 40 ns each side of every strobe edge, strobe still between frames
  always @(posedge clk_in)
  begin
    if (start_in && !busy_out)
    begin
      busy_out = 1'b1;
      lo_w = {use_m_in ? mask_in[7:0] : 8'hFF, data_in[63:0]};
      hi_w = {use_m_in ? mask_in[15:8] : 8'hFF, data_in[127:64]};
      if (width_in == 2'h0)
        lo_w = {40'hFF_FFFF_FFFF, data_in[31:0]};
      lo_c = crc8(lo_w);
      hi_c = crc8(hi_w);
      crc_out = {hi_c, lo_c};
      if (width_in == 2'h2)
        hi_c = hi_c ^ {7'h00, bad_in}; // at 16 bits wide the fault goes to the upper tree
      else
        lo_c = lo_c ^ {7'h00, bad_in}; // corrupted only on the bench's command
      #3; // step off the sampling edge so the pins never race the synchroniser
      pins_out.frame = 1'b1;
      #40;
      for (int t = 0; t < int'(nx_in); t++)
      begin
        for (int n = 0; n < NUM_LANES; n++)
          pins_out.lanes[n] = lane_bit(n, t);
        #40;
        pins_out.strobe = !pins_out.strobe;
        #40;
      end
      #60;
      pins_out.frame = 1'b0;
      pins_out.lanes = ~pins_out.lanes; // released lanes must not keep the last value
      #40;
      busy_out = 1'b0;
    end
  end
endmodule

// file: sim/tb_top.sv
// self-checking bench for the write checksum checker
`timescale 1ns/100ps
module tb_top
  import dwcrc_pkg::*;
;
  localparam int unsigned PW = 7;
  typedef struct packed { logic [1:0] w; logic m_en; logic i_en; logic bad; logic [3:0] nx; logic err; } dwcrc_row_t;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
  logic [ADDR_W-1:0] reg_addr;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, start = 1'b0, use_m = 1'b0, bad = 1'b0;
  logic [1:0] width = 2'h1;
  logic [3:0] nx = 4'hA;
  logic [127:0] data = '0, wr_data;
  logic [15:0] mask = 16'h0000, crc_sent;
  logic [15:0] sum_mask, exp_recv;
  logic busy, alert_n, alert_oe_n, wr_valid, alert_wire;
  dwcrc_pins_t pins;
  dwcrc_row_t r;
  int err_count = 0, check_count = 0, low_total = 0;
  // no row enables mask and inversion together; the last row uses the spare width code
  dwcrc_row_t rows [10] = '{'{2'h1, 1'b0, 1'b0, 1'b0, 4'hA, 1'b0}, '{2'h1, 1'b0, 1'b0, 1'b1, 4'hA, 1'b1},
    '{2'h1, 1'b1, 1'b0, 1'b0, 4'hA, 1'b0}, '{2'h1, 1'b0, 1'b1, 1'b1, 4'hA, 1'b1}, '{2'h0, 1'b0, 1'b0, 1'b0, 4'hA, 1'b0},
    '{2'h0, 1'b0, 1'b0, 1'b1, 4'hA, 1'b1}, '{2'h2, 1'b0, 1'b1, 1'b0, 4'hA, 1'b0}, '{2'h2, 1'b0, 1'b0, 1'b1, 4'hA, 1'b1},
    '{2'h1, 1'b0, 1'b0, 1'b0, 4'h8, 1'b1}, '{2'h3, 1'b0, 1'b0, 1'b1, 4'hA, 1'b1}};

  logic [DATA_W-1:0] reg_wdata_q = 16'h0000;
  always #5 clk_in = ~clk_in;
  assign reg_wdata = 16'h0000 | reg_wdata_q;
  assign alert_wire = alert_oe_n ? 1'b1 : alert_n; // pulled up when released
  initial reg_addr = 4'h0;
  // low cycles seen on the shared alert wire
  always @(posedge clk_in)
    if (alert_wire === 1'b0)
      low_total <= low_total + 1;

  dwcrc_ctrl_model ctrl_u (.clk_in(clk_in), .start_in(start), .width_in(width), .use_m_in(use_m), .bad_in(bad),
    .nx_in(nx), .data_in(data), .mask_in(mask), .busy_out(busy), .crc_out(crc_sent), .pins_out(pins));
  dwcrc_top #(.ALERT_PW_CYC(PW)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(wr_stb), .reg_rd_in(rd_stb), .reg_rdata_out(reg_rdata),
    .strobe_in(pins.strobe), .frame_in(pins.frame), .dq_in(pins.lanes[15:0]),
    .lower_mask_lane_in(pins.lanes[LOWER_MASK_LANE]), .upper_mask_lane_in(pins.lanes[UPPER_MASK_LANE]),
    .alert_n_out(alert_n), .alert_oe_n_out(alert_oe_n), .wr_valid_out(wr_valid), .wr_data_out(wr_data));

  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata_q <= d;
    wr_stb <= 1'b1;
    @(posedge clk_in);
    wr_stb <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge clk_in);
    reg_addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_in);
    rd_stb <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  // a wait that runs out counts as a mismatch and ends the run
  task automatic bound(input int k);
    if (k >= 300)
    begin
      $display("mismatch wait expected done seen timeout");
      err_count++;
      tally_and_finish();
    end
  endtask

  task automatic send_frame();
    int k;
    @(posedge clk_in);
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    for (k = 0; k < 300 && wr_valid !== 1'b1; k++)
      @(negedge clk_in);
    bound(k);
    check("burst data", data, wr_data);
    for (k = 0; k < 300 && busy !== 1'b0; k++)
      @(negedge clk_in);
    bound(k);
  endtask

  // frame with the given corruption, then the alert count after the pulse window
  task automatic frame_alert(input logic b, input int lows);
    bad <= b;
    low_total = 0;
    send_frame();
    repeat (30) @(posedge clk_in);
    check("alert low cycles", lows, low_total);
  endtask

  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      r = rows[i];
      reg_write(REG_MODE_FIVE, {10'h000, r.w, 1'b0, r.i_en, r.m_en, 1'b1});
      width <= r.w;
      use_m <= r.m_en | r.i_en;
      nx <= r.nx;
      data <= {4{32'hC3A5_0F1E}} ^ {16{i[7:0]}};
      mask <= 16'h5A3C ^ {2{i[7:0]}};
      frame_alert(r.bad, r.err ? PW : 0);
      reg_read(REG_MODE_FIVE);
      check("error clear bit", r.err, rd_val[MR5_ERR_CLR]);
      reg_read(REG_MPR_THREE);
      check("error status bit", r.err, rd_val[MULTIPURPOSE_REGISTER_THREE_ERR]);
      if (r.nx == 4'hA)
      begin
        sum_mask = (r.w == 2'h2) ? 16'hFFFF : 16'h00FF;
        exp_recv = crc_sent ^ ((r.w == 2'h2) ? {7'h00, r.bad, 8'h00} : {15'h0000, r.bad});
        reg_read(REG_CRC_CALC);
        check("computed sum", crc_sent & sum_mask, rd_val & sum_mask);
        reg_read(REG_CRC_RECV);
        check("received sum", exp_recv & sum_mask, rd_val & sum_mask);
      end
    end
    // sticky flag survives a write of one and a good retry
    reg_write(REG_MODE_FIVE, 16'h0011);
    width <= 2'h1;
    use_m <= 1'b0;
    nx <= 4'hA;
    frame_alert(1'b1, PW);
    reg_write(REG_MODE_FIVE, 16'h0019);
    frame_alert(1'b0, 0);
    reg_read(REG_MODE_FIVE);
    check("flag kept", 1'b1, rd_val[MR5_ERR_CLR]);
    reg_write(REG_MODE_FIVE, 16'h0011);
    reg_read(REG_MPR_THREE);
    check("flag cleared", 1'b0, rd_val[MULTIPURPOSE_REGISTER_THREE_ERR]);
    // two bad frames back to back give two full pulses
    bad <= 1'b1;
    low_total = 0;
    send_frame();
    send_frame();
    repeat (30) @(posedge clk_in);
    check("two pulses", 2 * PW, low_total);
    // checksum off: short bad frame raises nothing
    reg_write(REG_MODE_FIVE, 16'h0022);
    nx <= 4'h8;
    frame_alert(1'b1, 0);
    // second reset, read-only and unmapped places
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    reg_read(REG_MODE_FIVE);
    check("mode after reset", MR5_RESET, rd_val);
    reg_write(REG_MPR_THREE, 16'hFFFF);
    reg_read(REG_MPR_THREE);
    check("read-only status", 16'h0000, rd_val);
    reg_write(4'hF, 16'hFFFF);
    reg_read(4'hF);
    check("unmapped read", 16'h0000, rd_val);
    tally_and_finish();
  end
endmodule
